// ---- verilog/rfs_pkg.sv ----
`default_nettype none
// ----------------------------------------------------------------
// shared constants for reset flags and flash segment control
// ----------------------------------------------------------------
package rfs_pkg;
    // register byte offsets on the wishbone bus
    localparam logic [7:0] RFS_OFS_FLAGS  = 8'h02; // reset_cause_flags
    localparam logic [7:0] RFS_OFS_IRQST  = 8'h10; // sticky event status
    localparam logic [7:0] RFS_OFS_IRQMSK = 8'h14; // event mask
    localparam logic [7:0] RFS_OFS_FCTL   = 8'h18; // flash command
    localparam logic [7:0] RFS_OFS_FADDR  = 8'h1C; // flash byte address
    localparam logic [7:0] RFS_OFS_FDATA  = 8'h20; // flash write data
    localparam logic [7:0] RFS_OFS_FSTAT  = 8'h24; // flash status
    // flag bit positions
    localparam int RFS_BIT_WDT = 0;
    localparam int RFS_BIT_OSC = 1;
    localparam int RFS_BIT_POR = 2;
    localparam int RFS_BIT_RST = 3;
    localparam int RFS_BIT_NMI = 4;
    // flag values after power-on and after power-up clear
    localparam logic [4:0] RFS_FLAGS_POR = 5'h06;
    localparam logic [4:0] RFS_FLAGS_PUC_MASK = 5'h12;
    localparam logic [4:0] RFS_FLAGS_PUC_VAL  = 5'h02;
    // segment geometry
    localparam int RFS_MAIN_SEG_BYTES = 512;
    localparam int RFS_INFO_SEG_BYTES = 64;
    localparam int RFS_INFO_SEGS      = 4;
    // flash commands
    typedef enum logic [2:0] {
        RFS_CMD_NONE  = 3'h0,
        RFS_CMD_BYTE  = 3'h1,
        RFS_CMD_WORD  = 3'h2,
        RFS_CMD_SEG   = 3'h3,
        RFS_CMD_MASS  = 3'h4,
        RFS_CMD_ALL   = 3'h5
    } rfs_cmd_t;
    // flash controller states
    typedef enum logic [2:0] {
        RFS_ST_IDLE = 3'b001,
        RFS_ST_PROG = 3'b010,
        RFS_ST_ERAS = 3'b100
    } rfs_state_t;
    localparam logic [7:0] RFS_UNLOCK_KEY = 8'hA5;
    localparam logic [15:0] RFS_ERASED = 16'hFFFF;
endpackage : rfs_pkg
`default_nettype wire

// ---- verilog/rfs_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module rfs_top #(
    parameter int MAIN_SEGS = 8 // number of main segments
) (
    input  wire logic        clk_sys_in,    // 125 MHz system clock
    input  wire logic        reset_in,      // power-up clear, high
    input  wire logic        por_in,        // supply power-on, high
    input  wire logic        wdt_ovf_in,    // watchdog overflow pulse
    input  wire logic        wdt_rst_mode_in, // watchdog in reset mode
    input  wire logic        key_viol_in,   // wrong key pulse
    input  wire logic        rst_pin_n_in,  // reset/nmi pin, async
    input  wire logic        pin_nmi_mode_in, // pin in nmi mode
    input  wire logic        osc_fault_in,  // oscillator fault pulse
    input  wire logic        dbg_req_in,    // debug port command strobe
    input  wire logic [2:0]  dbg_cmd_in,    // debug port command
    input  wire logic [15:0] dbg_addr_in,   // debug port address
    input  wire logic [15:0] dbg_data_in,   // debug port data
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_out,       // level interrupt
    output logic             busy_out       // flash busy
);
    localparam int AW = $clog2(MAIN_SEGS * rfs_pkg::RFS_MAIN_SEG_BYTES);
    localparam int IW = $clog2(rfs_pkg::RFS_INFO_SEGS *
                               rfs_pkg::RFS_INFO_SEG_BYTES);
    localparam int MW = AW - 1; // main word index width
    localparam int NW = IW - 1; // info word index width

    // ------------------------------------------------------------
    // pin synchroniser and flag state
    // ------------------------------------------------------------
    logic [2:0]  pin_sync_q;   // three stage pin chain
    logic        pin_low_q;    // debounced pin state (active)
    logic [4:0]  flags_q;      // reset cause flags
    logic [4:0]  irq_st_q;     // sticky event status
    logic [4:0]  irq_msk_q;    // event mask
    logic        pin_evt;      // pin assert edge
    logic        wb_hit;       // bus cycle accepted this edge
    logic        wb_wr;        // write taken this edge
    logic [4:0]  evt;          // event vector

    // pin chain: first stage feeds only the second
    always_ff @(posedge clk_sys_in) begin
        pin_sync_q <= {pin_sync_q[1:0], ~rst_pin_n_in};
    end

    // state updates once second and third stages agree
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            pin_low_q <= 1'b0;
        end else if (pin_sync_q[1] == pin_sync_q[2]) begin
            pin_low_q <= pin_sync_q[2];
        end
    end

    assign pin_evt = (pin_sync_q[1] == pin_sync_q[2]) &&
                     pin_sync_q[2] && !pin_low_q;
    assign wb_hit  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr   = wb_hit && wb_we_i && wb_sel_i[0];

    // event vector in flag layout
    always_comb begin
        evt = 5'h00;
        evt[rfs_pkg::RFS_BIT_WDT] = (wdt_ovf_in && wdt_rst_mode_in) ||
                                    key_viol_in;
        evt[rfs_pkg::RFS_BIT_OSC] = osc_fault_in;
        // pin reset only in reset mode
        evt[rfs_pkg::RFS_BIT_RST] = pin_evt && !pin_nmi_mode_in;
        evt[rfs_pkg::RFS_BIT_NMI] = pin_evt && pin_nmi_mode_in;
    end

    // ------------------------------------------------------------
    // reset cause flags
    // ------------------------------------------------------------
    // power-on beats everything; set beats software clear
    always_ff @(posedge clk_sys_in) begin
        if (por_in) begin
            flags_q <= rfs_pkg::RFS_FLAGS_POR;
        end else if (reset_in) begin
            // soft clear only touches the puc-reset bits
            flags_q <= (flags_q & ~rfs_pkg::RFS_FLAGS_PUC_MASK) |
                       rfs_pkg::RFS_FLAGS_PUC_VAL;
        end else begin
            if (wb_wr && wb_adr_i == rfs_pkg::RFS_OFS_FLAGS) begin
                flags_q <= wb_dat_i[4:0] | evt;
            end else begin
                flags_q <= flags_q | evt;
            end
            if (evt[rfs_pkg::RFS_BIT_RST]) begin
                flags_q[rfs_pkg::RFS_BIT_WDT] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------
    // write one to clear; a new event wins over the clear
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            irq_st_q <= 5'h00;
        end else if (wb_wr && wb_adr_i == rfs_pkg::RFS_OFS_IRQST) begin
            irq_st_q <= (irq_st_q & ~wb_dat_i[4:0]) | evt;
        end else begin
            irq_st_q <= irq_st_q | evt;
        end
    end

    // mask register
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            irq_msk_q <= 5'h00;
        end else if (wb_wr && wb_adr_i == rfs_pkg::RFS_OFS_IRQMSK) begin
            irq_msk_q <= wb_dat_i[4:0];
        end
    end

    // registered interrupt line
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(irq_st_q & irq_msk_q);
        end
    end

    // ------------------------------------------------------------
    // flash arrays and controller
    // ------------------------------------------------------------
    // arrays sized by segment geometry
    logic [15:0] main_mem [MAIN_SEGS * rfs_pkg::RFS_MAIN_SEG_BYTES / 2];
    logic [15:0] info_mem [rfs_pkg::RFS_INFO_SEGS *
                           rfs_pkg::RFS_INFO_SEG_BYTES / 2];
    rfs_pkg::rfs_state_t st_q;     // controller state
    logic [2:0]  cmd_q;            // latched command
    logic [15:0] addr_q;           // latched address
    logic [15:0] data_q;           // latched data
    logic [15:0] fa_q;             // bus address register
    logic [15:0] fd_q;             // bus data register
    logic        lock_a_q;         // segment A lock
    logic        viol_q;           // locked-segment attempt seen
    logic        go;               // command request taken in idle, may be refused
    logic [2:0]  go_cmd;
    logic [15:0] go_addr;
    logic [15:0] go_data;
    logic        is_info;          // address selects info area
    logic        hits_a;           // operation touches segment A

    // bus writes to address and data registers
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            fa_q <= 16'h0000;
            fd_q <= 16'h0000;
        end else if (wb_wr) begin
            if (wb_adr_i == rfs_pkg::RFS_OFS_FADDR) begin
                fa_q <= wb_dat_i[15:0];
            end
            if (wb_adr_i == rfs_pkg::RFS_OFS_FDATA) begin
                fd_q <= wb_dat_i[15:0];
            end
        end
    end

    // debug port first, else cpu command write
    always_comb begin
        go      = 1'b0;
        go_cmd  = dbg_cmd_in;
        go_addr = dbg_addr_in;
        go_data = dbg_data_in;
        if (st_q == rfs_pkg::RFS_ST_IDLE) begin
            if (dbg_req_in) begin
                go = 1'b1;
            end else if (wb_wr && wb_adr_i == rfs_pkg::RFS_OFS_FCTL &&
                         wb_dat_i[2:0] != 3'h0) begin
                go      = 1'b1;
                go_cmd  = wb_dat_i[2:0];
                go_addr = fa_q;
                go_data = fd_q;
            end
        end
    end

    // info area flagged by top address bit, segment A is index 0
    assign is_info = go_addr[15];
    // single ops and the combined erase touch A
    assign hits_a = (is_info && go_addr[IW-1:IW-2] == 2'b00 &&
                     go_cmd != rfs_pkg::RFS_CMD_MASS) ||
                    go_cmd == rfs_pkg::RFS_CMD_ALL;

    // segment A lock: set on reset, key write loads it from bit 7
    always_ff @(posedge clk_sys_in) begin
        if (reset_in || por_in) begin
            lock_a_q <= 1'b1;
        end else if (wb_wr && wb_adr_i == rfs_pkg::RFS_OFS_FCTL) begin
            if (wb_dat_i[15:8] == rfs_pkg::RFS_UNLOCK_KEY) begin
                lock_a_q <= wb_dat_i[7];
            end
        end
    end

    // command latch and state sequencing
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            st_q   <= rfs_pkg::RFS_ST_IDLE;
            cmd_q  <= 3'h0;
            addr_q <= 16'h0000;
            data_q <= 16'h0000;
            viol_q <= 1'b0;
        end else begin
            // write one clears the violation in any state; a refusal
            // in the same cycle is assigned later and so wins
            if (wb_wr && wb_adr_i == rfs_pkg::RFS_OFS_FSTAT &&
                wb_dat_i[1]) begin
                viol_q <= 1'b0;
            end
            case (st_q)
                rfs_pkg::RFS_ST_IDLE: begin
                    if (go && hits_a && lock_a_q) begin
                        // refuse program or erase of A
                        viol_q <= 1'b1;
                    end else if (go) begin
                        cmd_q  <= go_cmd;
                        addr_q <= go_addr;
                        data_q <= go_data;
                        if (go_cmd == rfs_pkg::RFS_CMD_BYTE ||
                            go_cmd == rfs_pkg::RFS_CMD_WORD) begin
                            st_q <= rfs_pkg::RFS_ST_PROG;
                        end else if (go_cmd != rfs_pkg::RFS_CMD_NONE) begin
                            st_q <= rfs_pkg::RFS_ST_ERAS;
                        end
                    end
                end
                default: begin
                    st_q <= rfs_pkg::RFS_ST_IDLE;
                end
            endcase
        end
    end

    // array update: program one word or byte, erase whole segments in one cycle
    always_ff @(posedge clk_sys_in) begin
        if (st_q == rfs_pkg::RFS_ST_PROG) begin
            // byte or word program, flash only clears bits
            if (addr_q[15]) begin
                if (cmd_q == rfs_pkg::RFS_CMD_WORD) begin
                    info_mem[addr_q[IW-1:1]] <=
                        info_mem[addr_q[IW-1:1]] & data_q;
                end else if (addr_q[0]) begin
                    info_mem[addr_q[IW-1:1]][15:8] <=
                        info_mem[addr_q[IW-1:1]][15:8] & data_q[7:0];
                end else begin
                    info_mem[addr_q[IW-1:1]][7:0] <=
                        info_mem[addr_q[IW-1:1]][7:0] & data_q[7:0];
                end
            end else if (cmd_q == rfs_pkg::RFS_CMD_WORD) begin
                main_mem[addr_q[AW-1:1]] <=
                    main_mem[addr_q[AW-1:1]] & data_q;
            end else if (addr_q[0]) begin
                main_mem[addr_q[AW-1:1]][15:8] <=
                    main_mem[addr_q[AW-1:1]][15:8] & data_q[7:0];
            end else begin
                main_mem[addr_q[AW-1:1]][7:0] <=
                    main_mem[addr_q[AW-1:1]][7:0] & data_q[7:0];
            end
        end else if (st_q == rfs_pkg::RFS_ST_ERAS) begin
            // whole segment or all main segments
            for (int i = 0; i < (1 << MW); i++) begin
                if (cmd_q != rfs_pkg::RFS_CMD_SEG ? !addr_q[15] ||
                    cmd_q != rfs_pkg::RFS_CMD_SEG :
                    !addr_q[15] && i[MW-1:8] == addr_q[AW-1:9]) begin
                    main_mem[i] <= rfs_pkg::RFS_ERASED;
                end
            end
            // one info segment, or all with main
            for (int j = 0; j < (1 << NW); j++) begin
                if (cmd_q == rfs_pkg::RFS_CMD_ALL ||
                    (cmd_q == rfs_pkg::RFS_CMD_SEG && addr_q[15] &&
                     j[NW-1:5] == addr_q[IW-1:6])) begin
                    info_mem[j] <= rfs_pkg::RFS_ERASED;
                end
            end
        end
    end

    // busy flag out
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            busy_out <= 1'b0;
        end else begin
            busy_out <= go && !(hits_a && lock_a_q) &&
                        go_cmd != rfs_pkg::RFS_CMD_NONE;
        end
    end

    // ------------------------------------------------------------
    // wishbone read and acknowledge
    // ------------------------------------------------------------
    // one wait-free answer: ack the edge after stb, then drop
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= 32'h00000000;
            if (wb_hit && !wb_we_i) begin
                case (wb_adr_i)
                    rfs_pkg::RFS_OFS_FLAGS:  wb_dat_o[4:0] <= flags_q;
                    rfs_pkg::RFS_OFS_IRQST:  wb_dat_o[4:0] <= irq_st_q;
                    rfs_pkg::RFS_OFS_IRQMSK: wb_dat_o[4:0] <= irq_msk_q;
                    rfs_pkg::RFS_OFS_FADDR:  wb_dat_o[15:0] <= fa_q;
                    rfs_pkg::RFS_OFS_FDATA:  wb_dat_o[15:0] <= fd_q;
                    rfs_pkg::RFS_OFS_FSTAT:  wb_dat_o[2:0] <=
                        {lock_a_q, viol_q, st_q != rfs_pkg::RFS_ST_IDLE};
                    default:                 wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end
endmodule : rfs_top
`default_nettype wire

// ---- test/rfs_top_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// port checks for flags, flash and irq
// ----------------------------------------
module rfs_top_monitor (
    input wire logic        clk_sys_in,  // system clock
    input wire logic        reset_in,    // power-up clear
    input wire logic        dbg_req_in,  // debug command strobe
    input wire logic        wb_cyc_i,    // bus cycle
    input wire logic        wb_stb_i,    // bus strobe
    input wire logic        wb_we_i,     // bus direction
    input wire logic [7:0]  wb_adr_i,    // byte address
    input wire logic [31:0] wb_dat_i,    // write data
    input wire logic [31:0] wb_dat_o,    // read data
    input wire logic        wb_ack_o,    // bus answer
    input wire logic        irq_out,     // level interrupt
    input wire logic        busy_out     // flash accept pulse
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    logic       take;    // request taken this edge
    logic       wr;      // write taken this edge
    logic [2:0] since_q; // cycles since last flash command
    logic [4:0] mask_q;  // mask as last written, no reset needed
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr   = take && wb_we_i;
    // saturating age, so busy can be tied to its cause
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            since_q <= 3'h7;
        end else if (dbg_req_in || (wr && wb_adr_i == 8'h18)) begin
            since_q <= 3'h0;
        end else if (since_q != 3'h7) begin
            since_q <= since_q + 3'h1;
        end
    end
    // shadow of the event mask
    always_ff @(posedge clk_sys_in) begin
        if (wr && wb_adr_i == 8'h14) begin
            mask_q <= wb_dat_i[4:0];
        end
    end
    property p_ack_next; take |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack missing");
    property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held");
    property p_ack_cause;
        $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("data idle");
    property p_flags_width;
        wb_ack_o && $past(!wb_we_i && wb_adr_i == 8'h02)
            |-> wb_dat_o[31:5] == 27'h0;
    endproperty
    a_flags_width: assert property (p_flags_width)
        else $error("flag bits");
    property p_busy_pulse; busy_out |=> !busy_out; endproperty
    a_busy_pulse: assert property (p_busy_pulse)
        else $error("busy long");
    property p_busy_cause; busy_out |-> since_q <= 3'h3; endproperty
    a_busy_cause: assert property (p_busy_cause)
        else $error("stray busy");
    property p_irq_mask;
        irq_out |-> ($past(mask_q) | $past(mask_q, 2)) != 5'h0;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq masked");
    property p_irq_off;
        wr && wb_adr_i == 8'h14 && wb_dat_i[4:0] == 5'h0 |-> ##2 !irq_out;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq stays");
    c_busy: cover property (busy_out);
    c_irq: cover property ($rose(irq_out));
    c_flags: cover property (take && wb_adr_i == 8'h02);
endmodule // rfs_top_monitor
bind rfs_top rfs_top_monitor i_rfs_top_monitor (
    .clk_sys_in, .reset_in, .dbg_req_in, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_out, .busy_out
);
`default_nettype wire

// ---- test/rfs_dbg_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// external programming port model
// ----------------------------------------
module rfs_dbg_model (
    input  wire logic  clk_sys_in,   // system clock
    output logic       dbg_req_out,  // one-cycle strobe
    output logic [2:0] dbg_cmd_out,  // command code
    output logic [15:0] dbg_addr_out, // byte address
    output logic [15:0] dbg_data_out  // program data
);
    initial begin
        dbg_req_out  = 1'b0;
        dbg_cmd_out  = 3'h0;
        dbg_addr_out = 16'h0000;
        dbg_data_out = 16'h0000;
    end
    // strobe one command, but drop a segment erase of info segment A; lines stop showing it afterwards
    task automatic send(input logic [2:0] cmd, input logic [15:0] adr,
                        input logic [15:0] dat);
        if (cmd == 3'h3 && adr[15] && adr[7:6] == 2'h0) begin
            return;
        end
        @(posedge clk_sys_in);
        dbg_req_out  <= 1'b1;
        dbg_cmd_out  <= cmd;
        dbg_addr_out <= adr;
        dbg_data_out <= dat;
        @(posedge clk_sys_in);
        dbg_req_out  <= 1'b0;
        dbg_cmd_out  <= ~cmd;
        dbg_addr_out <= ~adr;
        dbg_data_out <= ~dat;
    endtask
endmodule // rfs_dbg_model
`default_nettype wire

// ---- test/test_rfs_top.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// bench for reset flags and flash control
// ----------------------------------------
module test_rfs_top;
    logic        clk_sys_in, reset_in, por_in;            // clock, resets
    logic        wdt_ovf_in, wdt_rst_mode_in, key_viol_in; // watchdog
    logic        osc_fault_in, rst_pin_n_in, pin_nmi_mode_in;
    logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;   // bus
    logic [7:0]  wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [3:0]  wb_sel_i;
    logic        irq_out, busy_out, dbg_req_in;
    logic [2:0]  dbg_cmd_in;
    logic [15:0] dbg_addr_in, dbg_data_in;
    int          n_fail, compares, n_busy;                // counters
    rfs_top #(.MAIN_SEGS(8)) i_rfs_top (
        .clk_sys_in, .reset_in, .por_in, .wdt_ovf_in, .wdt_rst_mode_in,
        .key_viol_in, .rst_pin_n_in, .pin_nmi_mode_in, .osc_fault_in,
        .dbg_req_in, .dbg_cmd_in, .dbg_addr_in, .dbg_data_in, .wb_cyc_i,
        .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o,
        .wb_ack_o, .irq_out, .busy_out
    );
    rfs_dbg_model i_rfs_dbg_model (
        .clk_sys_in, .dbg_req_out(dbg_req_in), .dbg_cmd_out(dbg_cmd_in),
        .dbg_addr_out(dbg_addr_in), .dbg_data_out(dbg_data_in)
    );
    initial begin
        clk_sys_in = 1'b0;
        forever #4 clk_sys_in = ~clk_sys_in;
    end
    // count accept pulses, sampled before the edge updates
    always @(posedge clk_sys_in) begin
        if (busy_out === 1'b1) n_busy++;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one classic cycle; waits for ack however long it takes
    task automatic xfer(input logic we, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_sys_in);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_sys_in); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask
    // one-cycle event: 0 watchdog, 1 key, 2 oscillator
    task automatic ev(input int k);
        @(posedge clk_sys_in);
        wdt_ovf_in   <= (k == 0);
        key_viol_in  <= (k == 1);
        osc_fault_in <= (k == 2);
        @(posedge clk_sys_in);
        {wdt_ovf_in, key_viol_in, osc_fault_in} <= 3'h0;
        repeat (4) @(posedge clk_sys_in);
    endtask
    // pin held low long enough for the synchroniser
    task automatic pin(input logic nmi);
        pin_nmi_mode_in <= nmi;
        rst_pin_n_in    <= 1'b0;
        repeat (6) @(posedge clk_sys_in);
        rst_pin_n_in <= 1'b1;
        repeat (6) @(posedge clk_sys_in);
    endtask
    // command through the cpu, then accept count and status
    task automatic cmd(input logic [2:0] c, input logic [15:0] a,
                       input int inc, input logic [31:0] st);
        int n0;
        n0 = n_busy;
        wr(rfs_pkg::RFS_OFS_FADDR, {16'h0, a});
        wr(rfs_pkg::RFS_OFS_FDATA, 32'h0000_0F0F);
        wr(rfs_pkg::RFS_OFS_FCTL, {29'h0, c});
        repeat (4) @(posedge clk_sys_in);
        check(32'(n_busy - n0), 32'(inc));
        rdc(rfs_pkg::RFS_OFS_FSTAT, st);
        wr(rfs_pkg::RFS_OFS_FSTAT, 32'h2);
    endtask
    task automatic give_verdict();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // cause flags: every source, clearing and cold start
    task automatic t_flags();
        rdc(8'h02, 32'h06);
        ev(0);
        rdc(8'h02, 32'h06);
        wdt_rst_mode_in <= 1'b1;
        ev(0);
        rdc(8'h02, 32'h07);
        wr(8'h02, 32'h0);
        ev(1);
        rdc(8'h02, 32'h01);
        pin(1'b0);
        rdc(8'h02, 32'h08);
        pin(1'b1);
        ev(2);
        rdc(8'h02, 32'h1A);
        por_in <= 1'b1;
        @(posedge clk_sys_in);
        por_in <= 1'b0;
        rdc(8'h02, 32'h06);
    endtask
    // sticky status, mask and the level output
    task automatic t_irq();
        wr(rfs_pkg::RFS_OFS_IRQST, 32'h1F);
        wr(rfs_pkg::RFS_OFS_IRQMSK, 32'h02);
        ev(2);
        check({31'h0, irq_out}, 32'h1);
        rdc(rfs_pkg::RFS_OFS_IRQST, 32'h02);
        wr(rfs_pkg::RFS_OFS_IRQMSK, 32'h0);
        repeat (3) @(posedge clk_sys_in);
        check({31'h0, irq_out}, 32'h0);
        wr(rfs_pkg::RFS_OFS_IRQMSK, 32'h02);
        repeat (3) @(posedge clk_sys_in);
        check({31'h0, irq_out}, 32'h1);
        wr(rfs_pkg::RFS_OFS_IRQST, 32'h02);
        repeat (3) @(posedge clk_sys_in);
        check({31'h0, irq_out}, 32'h0);
        wr(8'h40, 32'hFF);
        rdc(8'h40, 32'h0);
    endtask
    // segment a lock, all commands, debug port, warm reset
    task automatic t_flash();
        rdc(rfs_pkg::RFS_OFS_FSTAT, 32'h4);
        cmd(3'h1, 16'h803F, 0, 32'h6);
        cmd(3'h3, 16'h8000, 0, 32'h6);
        cmd(3'h1, 16'h8040, 1, 32'h4);
        wr(rfs_pkg::RFS_OFS_FCTL, 32'h0000_A500);
        for (int k = 1; k <= 5; k++) begin
            cmd(3'(k), k == 3 ? 16'h8000 : 16'h0200, 1, 32'h0);
        end
        cmd(3'h3, 16'h0400, 1, 32'h0);
        i_rfs_dbg_model.send(3'h1, 16'h0400, 16'h1234);
        i_rfs_dbg_model.send(3'h3, 16'h8010, 16'h0000);
        cmd(3'h0, 16'h0000, 1, 32'h0);
        wr(8'h02, 32'h10);
        reset_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        rdc(rfs_pkg::RFS_OFS_FSTAT, 32'h4);
        rdc(8'h02, 32'h02);
    endtask
    initial begin
        {n_fail, compares, n_busy} = '0;
        {reset_in, por_in, rst_pin_n_in, wb_sel_i} = 7'h7F;
        {wdt_ovf_in, wdt_rst_mode_in, key_viol_in, osc_fault_in} = 4'h0;
        {pin_nmi_mode_in, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h0;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0;
        repeat (10) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        por_in   <= 1'b0;
        t_flags();
        t_irq();
        t_flash();
        give_verdict();
    end
    // hang guard, far beyond the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        n_fail++;
        $display("Error at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        give_verdict();
    end
endmodule // test_rfs_top
`default_nettype wire
